// ==== verilog/pfcsv_pkg.sv ====
// Shared constants and carriers for the bulk voltage supervisor
// Assumes 125 MHz core clock; voltages in volts, 16-bit unsigned codes
package pfcsv_pkg;
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned BASE_HZ = 19200;
   localparam int unsigned BASE_DIV = CLK_HZ / BASE_HZ;
   localparam logic [12:0] BASE_DIV_M1 = 13'(BASE_DIV - 1);
   localparam logic [1:0] MED_DIV_M1 = 2'h3;
   localparam logic [15:0] BOOST_MARGIN_V = 16'h0019;
   localparam logic [15:0] VIN_MIN_V = 16'h0028;
   localparam logic [15:0] VIN_MAX_V = 16'h0113;
   localparam logic [15:0] VIN_DERATE_V = 16'h006E;
   localparam logic [15:0] BULK_MIN_V = 16'h0177;
   localparam logic [15:0] BULK_MAX_V = 16'h0198;
   localparam logic [15:0] PERIOD_MIN = 16'h0000;
   localparam logic [15:0] BULK_REF_RST = 16'h0190;
   localparam logic [31:0] KP_DEF = 32'h0000_0004;
   localparam logic [31:0] KI_DEF = 32'h0000_0001;

   typedef struct packed {
      logic [15:0] bulk_v;
      logic [15:0] vin_rms;
      logic [15:0] vin_inst;
      logic [15:0] vin_avg;
   } pfcsv_meas_s;

   typedef struct packed {
      logic ovr_cur;
      logic vin_fault;
      logic bulk_fault;
   } pfcsv_fault_s;

   typedef enum logic [1:0] {PRI_IDLE, PRI_LOW, PRI_MED, PRI_HIGH} pfcsv_pri_e;
endpackage

// ==== verilog/pfcsv_tick_gen.sv ====
// Base-rate timer and medium-rate tick divider
// Assumes a free-running core clock
`timescale 1ns/1ps
module pfcsv_tick_gen (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Ticks
   output logic base_tick_o,
   output logic med_tick_o
);
   logic [12:0] base_cnt_reg;
   logic [1:0] med_cnt_reg;
   wire base_wrap = (base_cnt_reg == pfcsv_pkg::BASE_DIV_M1);

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         base_cnt_reg <= 13'h0000;
         med_cnt_reg <= 2'h0;
         base_tick_o <= 1'b0;
         med_tick_o <= 1'b0;
      end else begin
         base_cnt_reg <= base_wrap ? 13'h0000 : base_cnt_reg + 13'h0001;
         base_tick_o <= base_wrap;
         if (base_wrap) begin
            med_cnt_reg <= med_cnt_reg + 2'h1;
         end
         med_tick_o <= base_wrap && (med_cnt_reg == pfcsv_pkg::MED_DIV_M1);
      end
   end

   chk_med_every_four: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) med_tick_o |-> base_tick_o &&
      (med_cnt_reg == 2'h0))
      else $error("medium tick out of step");
endmodule

// ==== verilog/pfcsv_cur_loop.sv ====
// One-phase inner current PI loop with mid-duty trigger placement
// Assumes conv_done_i pulses once per switching period
`timescale 1ns/1ps
module pfcsv_cur_loop (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic enable_i,
   input wire logic conv_done_i,
   input wire logic [15:0] iref_i,
   input wire logic [15:0] imeas_i,
   input wire logic [15:0] period_i,
   input wire logic ovr_cur_i,
   // Outputs
   output logic [15:0] duty_o,
   output logic [15:0] trig_o,
   output logic pwm_cut_o
);
   logic [31:0] integ_reg;
   wire [31:0] err = 32'(signed'({1'b0, iref_i})) - 32'({1'b0, imeas_i});
   wire [31:0] integ_next = integ_reg + err;
   wire [31:0] sum = integ_next + (err <<< 2);
   wire [15:0] duty_next = sum[31] ? 16'h0000 :
      ((sum[30:0] > 31'(period_i)) ? period_i : sum[15:0]);

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         integ_reg <= 32'h0000_0000;
         duty_o <= 16'h0000;
         trig_o <= 16'h0000;
         pwm_cut_o <= 1'b0;
      end else begin
         pwm_cut_o <= ovr_cur_i;
         if (!enable_i) begin
            integ_reg <= 32'h0000_0000;
            duty_o <= 16'h0000;
         end else if (conv_done_i) begin
            integ_reg <= integ_next;
            duty_o <= duty_next;
            trig_o <= {1'b0, duty_next[15:1]};
         end
      end
   end

   chk_trig_mid_duty: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) (enable_i && conv_done_i) |=>
      trig_o == {1'b0, duty_o[15:1]})
      else $error("trigger not at mid duty");
   chk_cut_follows: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) ovr_cur_i |=> pwm_cut_o)
      else $error("pulse not truncated");
endmodule

// ==== verilog/pfcsv_top.sv ====
// Bulk voltage supervisor: reference, loops, scheduling and faults
// Assumes measurements are synchronous and already scaled to volts
`timescale 1ns/1ps
module pfcsv_top #(
   parameter logic [31:0] BOOST_FACTOR = 32'h0000_0100,
   parameter logic [15:0] DEC_STEP = 16'h0001,
   parameter logic [255:0] BULK_TABLE = {16{16'h0190}}
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic reg_enable_i,
   input wire logic fault_clear_i,
   input wire logic bg_request_i,
   // Secondary side link
   input wire logic load_info_valid_i,
   input wire logic [3:0] load_index_i,
   input wire logic desired_valid_i,
   input wire logic [15:0] desired_bulk_i,
   // Measurements
   input wire pfcsv_pkg::pfcsv_meas_s meas_i,
   input wire logic phase_a_conversion_done_i,
   input wire logic phase_b_conversion_done_i,
   input wire logic [15:0] phase_a_current_i,
   input wire logic [15:0] phase_b_current_i,
   input wire logic phase_a_cmp_trip_i,
   input wire logic phase_b_cmp_trip_i,
   input wire logic [15:0] period_request_i,
   // Power stage
   output logic [15:0] phase_a_duty_o,
   output logic [15:0] phase_b_duty_o,
   output logic [15:0] phase_a_trig_o,
   output logic [15:0] phase_b_trig_o,
   output logic phase_a_pwm_cut_o,
   output logic phase_b_pwm_cut_o,
   output logic [15:0] period_o,
   output logic output_on_o,
   output logic power_derate_o,
   // Status
   output logic [15:0] bulk_ref_o,
   output logic [31:0] vpi_out_o,
   output logic [15:0] iref_o,
   output pfcsv_pkg::pfcsv_fault_s fault_o,
   output pfcsv_pkg::pfcsv_pri_e active_pri_o,
   output logic bg_grant_o
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] table_at(input logic [3:0] idx);
      table_at = BULK_TABLE[16*idx +: 16];
   endfunction

   function automatic logic above_by(input logic [15:0] a,
                                     input logic [15:0] b);
      above_by = ({1'b0, a} >= ({1'b0, b} + 17'(pfcsv_pkg::BOOST_MARGIN_V)));
   endfunction

   // ------------------------------------------------------------
   // Tick generation
   // ------------------------------------------------------------
   logic base_tick;
   logic medium_rate_task_tick;

   pfcsv_tick_gen u_tick (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .base_tick_o(base_tick),
      .med_tick_o(medium_rate_task_tick)
   );

   // ------------------------------------------------------------
   // Bulk reference selection
   // ------------------------------------------------------------
   logic [15:0] target_reg;
   logic [15:0] desired_reg;
   logic desired_pend_reg;
   logic [15:0] bulk_ref_next;
   logic [31:0] integ_reg;
   logic [15:0] period_reg;

   wire [15:0] bulk_v = meas_i.bulk_v;
   wire boost_hit = desired_pend_reg && above_by(desired_reg, bulk_v);
   wire target_up = target_reg > bulk_ref_o;
   wire target_dn = target_reg < bulk_ref_o;
   wire [15:0] gap = bulk_ref_o - target_reg;
   wire [15:0] dec_ref = (gap > DEC_STEP) ? bulk_ref_o - DEC_STEP
                                          : target_reg;
   wire undershoot = above_by(bulk_ref_o, bulk_v);

   always_comb begin
      bulk_ref_next = bulk_ref_o;
      if (boost_hit) begin
         bulk_ref_next = desired_reg;
      end else if (target_up) begin
         bulk_ref_next = target_reg;
      end else if (target_dn) begin
         bulk_ref_next = dec_ref;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         target_reg <= pfcsv_pkg::BULK_REF_RST;
         desired_reg <= 16'h0000;
         desired_pend_reg <= 1'b0;
         bulk_ref_o <= pfcsv_pkg::BULK_REF_RST;
      end else begin
         if (load_info_valid_i) begin
            target_reg <= table_at(load_index_i);
         end
         if (desired_valid_i) begin
            desired_reg <= desired_bulk_i;
            desired_pend_reg <= 1'b1;
         end else if (medium_rate_task_tick) begin
            desired_pend_reg <= 1'b0;
         end
         if (medium_rate_task_tick) begin
            bulk_ref_o <= bulk_ref_next;
         end
      end
   end

   // ------------------------------------------------------------
   // Outer voltage PI, 32-bit
   // ------------------------------------------------------------
   wire [31:0] verr = 32'({16'h0000, bulk_ref_o}) - 32'({16'h0000, bulk_v});
   wire [31:0] integ_add = integ_reg + 32'(verr * pfcsv_pkg::KI_DEF);
   wire [31:0] integ_new = undershoot ? integ_add + BOOST_FACTOR
                                      : integ_add;
   wire [31:0] vpi_new = integ_new + 32'(verr * pfcsv_pkg::KP_DEF);

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         integ_reg <= 32'h0000_0000;
         vpi_out_o <= 32'h0000_0000;
      end else if (!output_on_o) begin
         integ_reg <= 32'h0000_0000;
         vpi_out_o <= 32'h0000_0000;
      end else if (medium_rate_task_tick) begin
         integ_reg <= integ_new;
         vpi_out_o <= vpi_new[31] ? 32'h0000_0000 : vpi_new;
      end
   end

   // ------------------------------------------------------------
   // Sine-modulated current reference
   // ------------------------------------------------------------
   wire [31:0] avg_sq = 32'(meas_i.vin_avg) * 32'(meas_i.vin_avg);
   wire [47:0] prod = 48'(vpi_out_o[31:0]) * 48'(meas_i.vin_inst);
   wire [47:0] quo = (avg_sq == 32'h0000_0000) ? 48'h0000_0000_0000
                                              : prod / 48'(avg_sq);
   wire [15:0] iref_sat = (quo > 48'h0000_0000_FFFF) ? 16'hFFFF : quo[15:0];

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         iref_o <= 16'h0000;
      end else if (base_tick) begin
         iref_o <= iref_sat;
      end
   end

   // ------------------------------------------------------------
   // Switching period
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         period_reg <= pfcsv_pkg::PERIOD_MIN;
      end else if (medium_rate_task_tick) begin
         period_reg <= boost_hit ? pfcsv_pkg::PERIOD_MIN
                                 : period_request_i;
      end
   end
   assign period_o = period_reg;

   // ------------------------------------------------------------
   // Current loops
   // ------------------------------------------------------------
   pfcsv_cur_loop u_phase_a (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .enable_i(output_on_o),
      .conv_done_i(phase_a_conversion_done_i),
      .iref_i(iref_o),
      .imeas_i(phase_a_current_i),
      .period_i(period_reg),
      .ovr_cur_i(phase_a_cmp_trip_i),
      .duty_o(phase_a_duty_o),
      .trig_o(phase_a_trig_o),
      .pwm_cut_o(phase_a_pwm_cut_o)
   );

   pfcsv_cur_loop u_phase_b (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .enable_i(output_on_o),
      .conv_done_i(phase_b_conversion_done_i),
      .iref_i(iref_o),
      .imeas_i(phase_b_current_i),
      .period_i(period_reg),
      .ovr_cur_i(phase_b_cmp_trip_i),
      .duty_o(phase_b_duty_o),
      .trig_o(phase_b_trig_o),
      .pwm_cut_o(phase_b_pwm_cut_o)
   );

   // ------------------------------------------------------------
   // Faults and output enable
   // ------------------------------------------------------------
   wire vin_bad = (meas_i.vin_rms < pfcsv_pkg::VIN_MIN_V) ||
                  (meas_i.vin_rms > pfcsv_pkg::VIN_MAX_V);
   wire bulk_bad = (bulk_v < pfcsv_pkg::BULK_MIN_V) ||
                   (bulk_v > pfcsv_pkg::BULK_MAX_V);
   wire oc_any = phase_a_cmp_trip_i || phase_b_cmp_trip_i;
   wire any_fault = fault_o.vin_fault || fault_o.bulk_fault;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fault_o <= '0;
         output_on_o <= 1'b0;
         power_derate_o <= 1'b0;
      end else begin
         fault_o.vin_fault <= vin_bad || (fault_o.vin_fault &&
                              !fault_clear_i);
         fault_o.bulk_fault <= (bulk_bad && output_on_o) ||
                               (fault_o.bulk_fault &&
                                !fault_clear_i);
         fault_o.ovr_cur <= oc_any || (fault_o.ovr_cur &&
                            !fault_clear_i);
         output_on_o <= reg_enable_i && !vin_bad && !any_fault &&
                        !(bulk_bad && output_on_o);
         power_derate_o <= meas_i.vin_rms <
                           pfcsv_pkg::VIN_DERATE_V;
      end
   end

   // ------------------------------------------------------------
   // Task priority
   // ------------------------------------------------------------
   wire high_req = phase_a_conversion_done_i || phase_b_conversion_done_i;
   wire med_req = base_tick || medium_rate_task_tick;
   wire pfcsv_pkg::pfcsv_pri_e pri_next =
      high_req ? pfcsv_pkg::PRI_HIGH :
      med_req ? pfcsv_pkg::PRI_MED :
      bg_request_i ? pfcsv_pkg::PRI_LOW : pfcsv_pkg::PRI_IDLE;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         active_pri_o <= pfcsv_pkg::PRI_IDLE;
         bg_grant_o <= 1'b0;
      end else begin
         active_pri_o <= pri_next;
         bg_grant_o <= bg_request_i && !high_req && !med_req;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_med_up;
      medium_rate_task_tick && !boost_hit && target_up;
   endsequence

   chk_ref_raise_now: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) s_med_up |=> bulk_ref_o == $past(target_reg))
      else $error("reference not raised at once");
   chk_ref_step_down: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) (medium_rate_task_tick && !boost_hit &&
      target_dn) |=> (bulk_ref_o < $past(bulk_ref_o)) &&
      (bulk_ref_o >= $past(target_reg)))
      else $error("reference step down wrong");
   chk_boost_replace: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) (medium_rate_task_tick && boost_hit) |=>
      bulk_ref_o == $past(desired_reg))
      else $error("boost did not replace reference");
   chk_boost_wins: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) (medium_rate_task_tick && boost_hit &&
      target_dn) |=> bulk_ref_o == $past(desired_reg))
      else $error("reduction beat boost");
   chk_boost_period: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) (medium_rate_task_tick && boost_hit) |=>
      period_reg == pfcsv_pkg::PERIOD_MIN)
      else $error("period not reset on boost");
   chk_vin_shutdown: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) vin_bad |=> !output_on_o &&
      fault_o.vin_fault)
      else $error("input fault did not shut down");
   chk_bulk_shutdown: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) (bulk_bad && output_on_o) |=>
      !output_on_o ##1 !output_on_o)
      else $error("bulk fault did not shut down");
   chk_fault_sticky: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) (fault_o.vin_fault && !fault_clear_i) |=>
      fault_o.vin_fault)
      else $error("fault flag dropped");
   chk_bg_blocked: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) (high_req || med_req) |=> !bg_grant_o)
      else $error("background ran while busy");
   chk_high_first: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) high_req |=>
      active_pri_o == pfcsv_pkg::PRI_HIGH)
      else $error("conversion not top priority");
   sequence s_healthy;
      reg_enable_i && output_on_o && !vin_bad && !bulk_bad && !any_fault;
   endsequence
   sequence s_med_under;
      medium_rate_task_tick && output_on_o && undershoot;
   endsequence
   chk_trip_no_off: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) s_healthy ##0 oc_any |=> output_on_o)
      else $error("comparator trip shut the output down");
   chk_ref_hold: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) !medium_rate_task_tick |=> $stable(bulk_ref_o))
      else $error("reference moved off the medium tick");
   chk_integ_boost: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) s_med_under |=> integ_reg == $past(integ_reg)
      + 32'($past(verr) * pfcsv_pkg::KI_DEF) + BOOST_FACTOR)
      else $error("integral not boosted on undershoot");
   chk_derate_low: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) (meas_i.vin_rms < pfcsv_pkg::VIN_DERATE_V)
      |=> power_derate_o)
      else $error("low input not derated");
   chk_iref_base: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) !base_tick |=> $stable(iref_o))
      else $error("current reference moved off the base tick");
   chk_period_light: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) (medium_rate_task_tick && !boost_hit) |=>
      period_reg == $past(period_request_i))
      else $error("period request not taken");
   chk_pri_medium: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) (med_req && !high_req) |=>
      active_pri_o == pfcsv_pkg::PRI_MED)
      else $error("medium task not scheduled");
endmodule

// ==== testbench/pfcsv_far_model.sv ====
// Far-side model: secondary link messages and phase conversion events
// Assumes the bench calls its tasks from the core clock domain
`timescale 1ns/1ps
module pfcsv_far_model #(
   parameter int CONV_DIV = 1302
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Secondary link
   output logic load_info_valid_o,
   output logic [3:0] load_index_o,
   output logic desired_valid_o,
   output logic [15:0] desired_bulk_o,
   // Power stage sampling
   output logic conv_a_o,
   output logic conv_b_o,
   output logic [15:0] cur_a_o,
   output logic [15:0] cur_b_o
);
   int cnt;

   assign cur_a_o = 16'h0010;
   assign cur_b_o = 16'h0008;

   initial begin
      load_info_valid_o = 1'b0;
      load_index_o = 4'h0;
      desired_valid_o = 1'b0;
      desired_bulk_o = 16'h0000;
   end

   // ----------------------------------------
   // Conversions, phase b half a period later
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= 0;
         conv_a_o <= 1'b0;
         conv_b_o <= 1'b0;
      end else begin
         cnt <= (cnt == CONV_DIV - 1) ? 0 : cnt + 1;
         conv_a_o <= (cnt == 0);
         conv_b_o <= (cnt == CONV_DIV / 2);
      end
   end

   // ----------------------------------------
   // Link messages; released data is inverted
   // ----------------------------------------
   task automatic send_load(input logic [3:0] idx);
      @(posedge core_clk_i);
      load_index_o <= idx;
      load_info_valid_o <= 1'b1;
      @(posedge core_clk_i);
      load_info_valid_o <= 1'b0;
      load_index_o <= ~idx;
   endtask

   task automatic send_desired(input logic [15:0] v);
      @(posedge core_clk_i);
      desired_bulk_o <= v;
      desired_valid_o <= 1'b1;
      @(posedge core_clk_i);
      desired_valid_o <= 1'b0;
      desired_bulk_o <= ~v;
   endtask
endmodule

// ==== testbench/tb.sv ====
// Bench for the bulk voltage supervisor top
// Assumes the far-side model supplies link messages and conversions
`timescale 1ns/1ps
module tb;
   // ----------------------------------------
   // Stimulus and wiring
   // ----------------------------------------
   localparam logic [255:0] TABLE = {{5{16'h0190}}, 16'h01A9,
      {4{16'h0190}}, 16'h01A9, {5{16'h0190}}};
   localparam logic [15:0] STEP = 16'h0002;
   localparam logic [31:0] BOOST = 32'h0000_0100;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic reg_enable_i = 1'b1;
   logic fault_clear_i = 1'b0;
   logic bg_request_i = 1'b0;
   logic trip_a = 1'b0;
   logic trip_b = 1'b0;
   logic [15:0] period_req = 16'h03E8;
   pfcsv_pkg::pfcsv_meas_s meas = '{16'h0190, 16'h00E6, 16'h0064, 16'h00C8};
   logic [15:0] vin_set [6] = '{16'h0027, 16'h0028, 16'h006D, 16'h006E,
      16'h0113, 16'h0114};
   logic [15:0] bulk_set [4] = '{16'h0176, 16'h0177, 16'h0198, 16'h0199};
   logic load_v, des_v, conv_a, conv_b;
   logic [3:0] load_idx;
   logic [15:0] des_bulk, cur_a, cur_b, duty_a, duty_b, trig_a, trig_b;
   logic cut_a, cut_b, output_on_o, power_derate_o, bg_grant_o;
   logic [15:0] period_o, bulk_ref_o, iref_o;
   logic [31:0] vpi_out_o;
   pfcsv_pkg::pfcsv_fault_s fault_o;
   pfcsv_pkg::pfcsv_pri_e active_pri_o;
   int num_errors = 0;
   int n_checks = 0;

   initial begin
      forever #4 core_clk_i = ~core_clk_i;
   end

   pfcsv_far_model pfcsv_far_model_inst (.core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i), .load_info_valid_o(load_v),
      .load_index_o(load_idx), .desired_valid_o(des_v),
      .desired_bulk_o(des_bulk), .conv_a_o(conv_a), .conv_b_o(conv_b),
      .cur_a_o(cur_a), .cur_b_o(cur_b));

   pfcsv_top #(.BOOST_FACTOR(BOOST), .DEC_STEP(STEP), .BULK_TABLE(TABLE))
   pfcsv_top_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .reg_enable_i(reg_enable_i), .fault_clear_i(fault_clear_i),
      .bg_request_i(bg_request_i), .load_info_valid_i(load_v),
      .load_index_i(load_idx), .desired_valid_i(des_v),
      .desired_bulk_i(des_bulk), .meas_i(meas),
      .phase_a_conversion_done_i(conv_a), .phase_b_conversion_done_i(conv_b),
      .phase_a_current_i(cur_a), .phase_b_current_i(cur_b),
      .phase_a_cmp_trip_i(trip_a), .phase_b_cmp_trip_i(trip_b),
      .period_request_i(period_req), .phase_a_duty_o(duty_a),
      .phase_b_duty_o(duty_b), .phase_a_trig_o(trig_a),
      .phase_b_trig_o(trig_b), .phase_a_pwm_cut_o(cut_a),
      .phase_b_pwm_cut_o(cut_b), .period_o(period_o),
      .output_on_o(output_on_o), .power_derate_o(power_derate_o),
      .bulk_ref_o(bulk_ref_o), .vpi_out_o(vpi_out_o), .iref_o(iref_o),
      .fault_o(fault_o), .active_pri_o(active_pri_o),
      .bg_grant_o(bg_grant_o));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   task automatic wait_on();
      for (int n = 0; n < 200; n++) begin
         if (output_on_o === 1'b1) begin
            return;
         end
         step(1);
      end
      num_errors++;
      report_and_stop();
   endtask

   task automatic wait_ref(output int n);
      logic [15:0] prev;
      prev = bulk_ref_o;
      for (n = 1; n <= 27000; n++) begin
         step(1);
         if (bulk_ref_o !== prev) begin
            return;
         end
      end
      num_errors++;
      report_and_stop();
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic fault_case(input logic is_bulk, input logic [15:0] v);
      logic bad;
      bad = is_bulk ? (v < pfcsv_pkg::BULK_MIN_V || v > pfcsv_pkg::BULK_MAX_V)
         : (v < pfcsv_pkg::VIN_MIN_V || v > pfcsv_pkg::VIN_MAX_V);
      @(posedge core_clk_i);
      if (is_bulk) begin
         meas.bulk_v <= v;
      end else begin
         meas.vin_rms <= v;
      end
      step(3);
      check(is_bulk ? fault_o.bulk_fault : fault_o.vin_fault, bad);
      check(output_on_o, !bad);
      if (!is_bulk) begin
         check(power_derate_o, v < pfcsv_pkg::VIN_DERATE_V);
      end
      @(posedge core_clk_i);
      meas.bulk_v <= 16'h0190;
      meas.vin_rms <= 16'h00E6;
      step(3);
      check(is_bulk ? fault_o.bulk_fault : fault_o.vin_fault, bad);
      @(posedge core_clk_i);
      fault_clear_i <= 1'b1;
      @(posedge core_clk_i);
      fault_clear_i <= 1'b0;
      step(2);
      check(fault_o, 3'b000);
      wait_on();
   endtask

   task automatic t_trip();
      @(posedge core_clk_i);
      trip_a <= 1'b1;
      step(2);
      check({cut_a, cut_b, output_on_o}, 3'b101);
      @(posedge core_clk_i);
      trip_a <= 1'b0;
      trip_b <= 1'b1;
      step(2);
      check({cut_a, cut_b, output_on_o}, 3'b011);
      @(posedge core_clk_i);
      trip_b <= 1'b0;
      step(2);
      check({cut_a, cut_b, output_on_o}, 3'b001);
   endtask

   task automatic t_prio();
      int n;
      @(posedge core_clk_i);
      bg_request_i <= 1'b1;
      meas.vin_avg <= 16'h0008;
      step(3);
      check(bg_grant_o, 1'b1);
      step(pfcsv_pkg::BASE_DIV + 1400);
      check(iref_o, 16'h0431);
      check(vpi_out_o, 32'h0000_02AF);
      for (n = 0; n < 2000 && conv_a !== 1'b1; n++) begin
         step(1);
      end
      check(n < 2000, 1'b1);
      step(1);
      check(active_pri_o, pfcsv_pkg::PRI_HIGH);
      check(bg_grant_o, 1'b0);
      step(2);
      check(trig_a, duty_a >> 1);
      check(trig_b, duty_b >> 1);
      check(duty_a <= period_o, 1'b1);
      check(duty_a, 16'h03E8);
      check(duty_b, 16'h03E8);
      @(posedge core_clk_i);
      bg_request_i <= 1'b0;
   endtask

   task automatic t_ref();
      int n;
      logic [31:0] v1;
      pfcsv_far_model_inst.send_load(4'h5);
      wait_ref(n);
      check(bulk_ref_o, 16'h01A9);
      v1 = vpi_out_o;
      pfcsv_far_model_inst.send_load(4'h0);
      pfcsv_far_model_inst.send_desired(16'h01AE);
      wait_ref(n);
      check(bulk_ref_o, 16'h01AE);
      check(period_o, pfcsv_pkg::PERIOD_MIN);
      check(vpi_out_o - v1 >= BOOST, 1'b1);
      wait_ref(n);
      check(bulk_ref_o, 16'h01AE - STEP);
      check(n, 4 * pfcsv_pkg::BASE_DIV);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      step(1);
      check(bulk_ref_o, 16'h0190);
      check(fault_o, 3'b000);
      wait_on();
      foreach (vin_set[i]) begin
         fault_case(1'b0, vin_set[i]);
      end
      foreach (bulk_set[i]) begin
         fault_case(1'b1, bulk_set[i]);
      end
      t_trip();
      t_ref();
      t_prio();
      report_and_stop();
   end
endmodule
